//--- design/kms_ctrl.sv
// Key matrix scan controller with event queue and Avalon-MM registers
`timescale 1ns/1ps
`include "kms_map.svh"
module kms_ctrl import kms_pkg::*; #(
  parameter int TICK_CYCLES = `KMS_TICK_NS / `KMS_CLK_NS,
  // Base slave address, value arbitrary
  parameter logic [6:0] SLAVE_BASE = 7'h38
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Key matrix
  input wire logic [7:0] matrix_row_in,
  output logic [7:0] matrix_col_out,
  output logic [7:0] matrix_col_oe,
  // Key interrupt pin, open drain
  output logic key_irq_n_out,
  output logic key_irq_n_oe,
  // Slave address strap
  input wire logic [1:0] slave_addr_select,
  output logic [6:0] slave_addr
);
  localparam int SETTLE_CYC = `KMS_SETTLE_CYC;

  // ==========================================================
  // Declarations
  logic ack_q;
  logic [7:0] rd_q;
  logic rd_pop_q;
  logic rd_ovf_q;
  logic [7:0] cfg_q, deb_q, int_q, gpo_q, rpt_q, slp_q;
  kms_state_t state_q;
  logic [31:0] tick_cnt_q;
  logic [7:0] row_s;
  logic [1:0] asel_s;
  logic [2:0] col_q;
  logic [4:0] slot_q;
  logic [7:0][7:0] stable_q;
  logic [7:0][7:0] cand_q;
  logic [7:0][4:0] dcnt_q;
  logic [7:0] pend_q, pnew_q;
  logic [2:0] pcol_q;
  logic [2:0] prow;
  logic rpt_act_q, rpt_first_q;
  logic [5:0] rpt_key_q;
  logic [7:0] rpt_cnt_q;
  kms_event_t mem [16];
  logic [3:0] wp_q, rp_q;
  logic [4:0] cnt_q;
  logic ovf_q;
  logic [7:0] per_cnt_q;
  logic irq_q;
  logic irq_oe_q;
  logic [10:0] idle_q;
  logic [7:0] col_out_q, col_oe_q;
  logic [7:0] col_out_d, col_oe_d, gpo_mask;
  logic [1:0] strap_cnt_q;
  logic [1:0] asel_q;

  // ==========================================================
  // Bus slave
  wire req = avs_read | avs_write;
  wire first = req & ~ack_q;
  wire [5:0] idx = avs_address[7:2];
  wire [7:0] wdat = avs_writedata[7:0];
  wire wr_fire = avs_write & ack_q & avs_byteenable[0];
  wire sel_fifo = idx == `KMS_IDX_FIFO;
  wire sel_cfg = idx == `KMS_IDX_CFG;
  wire sel_deb = idx == `KMS_IDX_DEB;
  wire sel_int = idx == `KMS_IDX_INT;
  wire sel_gpo = idx == `KMS_IDX_GPO;
  wire sel_rpt = idx == `KMS_IDX_RPT;
  wire sel_slp = idx == `KMS_IDX_SLP;
  wire cfg_wr = wr_fire & sel_cfg;
  wire rd_done = avs_read & ack_q;
  wire pop = rd_done & rd_pop_q;
  wire ovf_clr = rd_done & rd_ovf_q;
  // Next entry with the more-pending status in bit 6
  wire [7:0] fifo_word = ovf_q ? `KMS_FIFO_OVF :
    (cnt_q == 5'd0) ? `KMS_FIFO_EMPTY :
    {mem[rp_q][6], cnt_q > 5'd1, mem[rp_q][5:0]};
  wire [7:0] cfg_rd = {state_q == st_sleep, cfg_q[6:0]};
  wire [7:0] rd_d = sel_fifo ? fifo_word : sel_cfg ? cfg_rd :
    sel_deb ? deb_q : sel_int ? int_q : sel_gpo ? gpo_q :
    sel_rpt ? rpt_q : sel_slp ? slp_q : 8'h00;
  assign avs_waitrequest = first;
  assign avs_readdata = {24'h000000, rd_q};

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rd_q <= 8'h00;
      rd_pop_q <= 1'b0;
      rd_ovf_q <= 1'b0;
    end else begin
      ack_q <= first;
      if (first && avs_read) begin
        rd_q <= rd_d;
        rd_pop_q <= sel_fifo && !ovf_q && cnt_q != 5'd0;
        rd_ovf_q <= sel_fifo && ovf_q;
      end
    end
  end

  // The queue register takes no writes
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= `KMS_RST_CFG;
      deb_q <= `KMS_RST_DEB;
      int_q <= `KMS_RST_INT;
      gpo_q <= `KMS_RST_GPO;
      rpt_q <= `KMS_RST_RPT;
      slp_q <= `KMS_RST_SLP;
    end else if (wr_fire) begin
      if (sel_cfg) cfg_q <= wdat;
      if (sel_deb) deb_q <= wdat;
      if (sel_int) int_q <= wdat;
      if (sel_gpo) gpo_q <= wdat;
      if (sel_rpt) rpt_q <= wdat;
      if (sel_slp) slp_q <= wdat;
    end
  end

  // ==========================================================
  // Time base and synchronisers
  wire tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (reset || tick) tick_cnt_q <= 32'h00000000;
    else tick_cnt_q <= tick_cnt_q + 32'h00000001;
  end

  kms_sync #(.WIDTH(8)) u_row_sync (
    .clk(clk),
    .reset(reset),
    .async_in(matrix_row_in),
    .sync_out(row_s)
  );

  kms_sync #(.WIDTH(2)) u_addr_sync (
    .clk(clk),
    .reset(reset),
    .async_in(slave_addr_select),
    .sync_out(asel_s)
  );

  // ==========================================================
  // Column drive and output columns
  wire [2:0] gpo_code = deb_q[`KMS_DEB_GPO];
  wire gpo_valid = gpo_code != 3'd0 && gpo_code != 3'd7;
  wire sleeping = state_q == st_sleep;

  genvar c;
  for (c = 0; c < 8; c = c + 1) begin : g_col
    if (c < 2) begin : g_key
      assign gpo_mask[c] = 1'b0;
    end else begin : g_opt
      assign gpo_mask[c] = gpo_valid && {1'b0, gpo_code} >= 4'(8 - c);
    end
    // Sleep drives every key column so any press is seen
    assign col_out_d[c] = !gpo_mask[c] && (sleeping || col_q == 3'(c));
    assign col_oe_d[c] = gpo_mask[c] ? !gpo_q[c] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      col_out_q <= 8'h00;
      col_oe_q <= 8'hff;
    end else begin
      col_out_q <= col_out_d;
      col_oe_q <= col_oe_d;
    end
  end

  assign matrix_col_out = col_out_q;
  assign matrix_col_oe = col_oe_q;

  // ==========================================================
  // Scan and debounce
  wire pend_ev = pend_q != 8'h00;
  wire scan_en = state_q == st_run && !pend_ev;
  wire sample = scan_en && slot_q == 5'(SETTLE_CYC - 1);
  wire [7:0] rows_now = gpo_mask[col_q] ? 8'h00 : row_s;
  wire [7:0] stab_c = stable_q[col_q];
  wire settled = dcnt_q[col_q] >= deb_q[`KMS_DEB_TIME];
  wire key_held = stable_q != 64'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      col_q <= 3'd0;
      slot_q <= 5'd0;
    end else if (sample) begin
      col_q <= col_q + 3'd1;
      slot_q <= 5'd0;
    end else if (scan_en) begin
      slot_q <= slot_q + 5'd1;
    end
  end

  // Lowest changed row of the pending column goes first
  always_comb begin
    prow = 3'd0;
    for (int r = 7; r >= 0; r--) begin
      if (pend_q[r]) prow = 3'(r);
    end
  end

  wire pend_rel = !pnew_q[prow];
  wire pend_push = pend_ev && (!pend_rel || cfg_q[`KMS_CFG_REL]);
  wire [5:0] ev_key = {pcol_q, prow};

  always_ff @(posedge clk) begin
    if (reset) begin
      stable_q <= '0;
      cand_q <= '0;
      dcnt_q <= '0;
      pend_q <= 8'h00;
      pnew_q <= 8'h00;
      pcol_q <= 3'd0;
    end else if (pend_ev) begin
      pend_q[prow] <= 1'b0;
    end else if (sample) begin
      if (rows_now == stab_c) begin
        cand_q[col_q] <= stab_c;
        dcnt_q[col_q] <= 5'd0;
      end else if (rows_now != cand_q[col_q]) begin
        cand_q[col_q] <= rows_now;
        dcnt_q[col_q] <= 5'd0;
      end else if (settled) begin
        stable_q[col_q] <= rows_now;
        dcnt_q[col_q] <= 5'd0;
        pend_q <= gpo_mask[col_q] ? 8'h00 : rows_now ^ stab_c;
        pnew_q <= rows_now;
        pcol_q <= col_q;
      end else begin
        dcnt_q[col_q] <= dcnt_q[col_q] + 5'd1;
      end
    end
  end

  // ==========================================================
  // Autorepeat of the last pressed key
  wire rpt_on = rpt_q[`KMS_RPT_DELAY] != 4'h0;
  wire [7:0] rpt_lim = rpt_first_q ? {rpt_q[`KMS_RPT_DELAY], 4'h0} :
    {4'h0, rpt_q[`KMS_RPT_RATE]} + 8'd1;
  wire rpt_held = stable_q[rpt_key_q[5:3]][rpt_key_q[2:0]];
  wire rpt_fire = rpt_act_q && rpt_on && rpt_held &&
    rpt_cnt_q >= rpt_lim && !pend_ev;
  wire press_ev = pend_push && !pend_rel;

  always_ff @(posedge clk) begin
    if (reset) begin
      rpt_act_q <= 1'b0;
      rpt_first_q <= 1'b0;
      rpt_key_q <= 6'd0;
      rpt_cnt_q <= 8'h00;
    end else if (press_ev) begin
      rpt_act_q <= 1'b1;
      rpt_first_q <= 1'b1;
      rpt_key_q <= ev_key;
      rpt_cnt_q <= 8'h00;
    end else if (rpt_fire) begin
      rpt_first_q <= 1'b0;
      rpt_cnt_q <= 8'h00;
    end else if (!rpt_held) begin
      rpt_act_q <= 1'b0;
    end else if (tick && rpt_cnt_q != 8'hff) begin
      rpt_cnt_q <= rpt_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Event queue
  wire ev_push = pend_push | rpt_fire;
  wire kms_event_t ev_data = pend_push ? {pend_rel, ev_key} :
    {1'b0, rpt_key_q};
  wire full = cnt_q == `KMS_FIFO_DEPTH;
  wire push = ev_push && !full;

  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= ev_data;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'd0;
      ovf_q <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + 4'h1;
      if (pop) rp_q <= rp_q + 4'h1;
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
      // A new overflow beats the clearing read
      if (ev_push && full) ovf_q <= 1'b1;
      else if (ovf_clr) ovf_q <= 1'b0;
    end
  end

  // ==========================================================
  // Key interrupt
  wire [4:0] thr = int_q[`KMS_INT_THR];
  wire [7:0] per_lim = {2'b00, int_q[`KMS_INT_PER], 3'b000};
  wire per_fire = per_lim != 8'h00 && cnt_q != 5'd0 && tick &&
    per_cnt_q + 8'h01 >= per_lim;
  wire irq_set = (thr != 5'd0 && cnt_q >= thr) || per_fire;
  wire gpo_irq = gpo_q[`KMS_GPO_IRQ_EN];

  always_ff @(posedge clk) begin
    if (reset) begin
      per_cnt_q <= 8'h00;
      irq_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      if (cnt_q == 5'd0 || per_fire) per_cnt_q <= 8'h00;
      else if (tick) per_cnt_q <= per_cnt_q + 8'h01;
      if (irq_set) irq_q <= 1'b1;
      else if (pop) irq_q <= 1'b0;
      irq_oe_q <= gpo_irq ? !gpo_q[`KMS_GPO_IRQ_LVL] : irq_q;
    end
  end

  assign key_irq_n_out = 1'b0;
  assign key_irq_n_oe = irq_oe_q;

  // ==========================================================
  // Sleep and wake
  wire [10:0] idle_lim = 11'(slp_q[`KMS_SLP_TIME]) * `KMS_SLEEP_STEP;
  wire asleep_go = cfg_q[`KMS_CFG_ASLEEP] && idle_lim != 11'd0 &&
    !key_held && idle_q >= idle_lim;
  wire wake_go = cfg_q[`KMS_CFG_AWAKE] && row_s != 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= st_sleep;
    end else begin
      unique case (state_q)
        st_sleep: begin
          if (cfg_wr ? !wdat[`KMS_CFG_SLEEP] : wake_go) state_q <= st_run;
        end
        st_run: begin
          if (cfg_wr ? wdat[`KMS_CFG_SLEEP] : asleep_go) state_q <= st_sleep;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_q != st_run || ev_push || key_held) begin
      idle_q <= 11'd0;
    end else if (tick && idle_q != 11'h7ff) begin
      idle_q <= idle_q + 11'd1;
    end
  end

  // ==========================================================
  // Address strap, caught once the synchroniser has filled
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_cnt_q <= 2'd0;
      asel_q <= 2'd0;
    end else if (strap_cnt_q != 2'd3) begin
      strap_cnt_q <= strap_cnt_q + 2'd1;
      if (strap_cnt_q == 2'd2) asel_q <= asel_s;
    end
  end

  assign slave_addr = {SLAVE_BASE[6:2], asel_q};

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence bus_ans_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence empty_cap_s;
    first && avs_read && sel_fifo && !ovf_q && cnt_q == 5'd0;
  endsequence

  bus_answer_a: assert property (
    $rose(req) |-> bus_ans_s) else $error("bus answer not one wait");
  empty_read_a: assert property (
    empty_cap_s |=> avs_readdata == 32'h0000003f)
    else $error("empty queue read wrong");
  pop_count_a: assert property (
    pop && !push |=> cnt_q == $past(cnt_q) - 5'd1)
    else $error("read did not remove entry");
  fifo_bound_a: assert property (
    cnt_q <= `KMS_FIFO_DEPTH) else $error("queue count over depth");
  held_awake_a: assert property (
    state_q == st_run && key_held && !cfg_wr |=> state_q == st_run)
    else $error("slept with key held");
  sleep_go_a: assert property (
    state_q == st_run && asleep_go && !cfg_wr |=> state_q == st_sleep)
    else $error("autosleep missed");
  sleep_keep_a: assert property (
    sleeping && !ev_push && !pop |=> $stable(cnt_q) && $stable(rp_q))
    else $error("queue lost in sleep");
  wake_key_a: assert property (
    sleeping && wake_go && !cfg_wr |=> state_q == st_run ##1 !sleeping)
    else $error("autowake missed");
  reset_init_a: assert property (
    $past(reset) |-> sleeping && cfg_q == `KMS_RST_CFG &&
    slp_q == `KMS_RST_SLP && int_q == `KMS_RST_INT)
    else $error("bad state after reset");
  col_keep_a: assert property (
    matrix_col_oe[1:0] == 2'b11 && $countones(gpo_mask) <= 6)
    else $error("illegal output column");
  irq_pin_a: assert property (
    irq_set && !gpo_irq |=> irq_q ##1 (key_irq_n_oe || gpo_irq))
    else $error("key interrupt not driven");
  gpo_pin_a: assert property (
    gpo_irq |=> !key_irq_n_out &&
    key_irq_n_oe == !$past(gpo_q[`KMS_GPO_IRQ_LVL]))
    else $error("interrupt pin output wrong");
endmodule // kms_ctrl

//--- shared/kms_map.svh
// Register indices, field positions, reset values and timing counts
`ifndef KMS_MAP_SVH
`define KMS_MAP_SVH
`define KMS_IDX_FIFO 6'h00
`define KMS_IDX_CFG 6'h01
`define KMS_IDX_DEB 6'h02
`define KMS_IDX_INT 6'h03
`define KMS_IDX_GPO 6'h04
`define KMS_IDX_RPT 6'h05
`define KMS_IDX_SLP 6'h06
`define KMS_RST_CFG 8'h0a
`define KMS_RST_DEB 8'hff
`define KMS_RST_INT 8'h00
`define KMS_RST_GPO 8'hfe
`define KMS_RST_RPT 8'h00
`define KMS_RST_SLP 8'h07
`define KMS_FIFO_EMPTY 8'h3f
`define KMS_FIFO_OVF 8'h7f
`define KMS_FIFO_DEPTH 5'd16
`define KMS_CFG_SLEEP 7
`define KMS_CFG_REL 5
`define KMS_CFG_ASLEEP 3
`define KMS_CFG_AWAKE 1
`define KMS_DEB_TIME 4:0
`define KMS_DEB_GPO 7:5
`define KMS_INT_THR 4:0
`define KMS_INT_PER 7:5
`define KMS_GPO_IRQ_EN 0
`define KMS_GPO_IRQ_LVL 1
`define KMS_RPT_DELAY 3:0
`define KMS_RPT_RATE 7:4
`define KMS_SLP_TIME 2:0
`define KMS_CLK_NS 5
`define KMS_TICK_NS 1000000
`define KMS_SETTLE_NS 80
`define KMS_SETTLE_CYC ((`KMS_SETTLE_NS + `KMS_CLK_NS - 1) / `KMS_CLK_NS)
`define KMS_SLEEP_STEP 11'd256
`endif

//--- shared/kms_pkg.sv
// Types shared by the key matrix scan controller
package kms_pkg;
  typedef enum logic {st_sleep, st_run} kms_state_t;
  // Queue entry: release flag, then key number
  typedef logic [6:0] kms_event_t;
endpackage

//--- design/kms_sync.sv
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module kms_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // kms_sync

//--- verification/kms_key_matrix.sv
// Key matrix model: closed switches tie driven columns to rows
`timescale 1ns/1ps
module kms_key_matrix (
  // Column drive from the controller
  input wire logic [7:0] matrix_col_out,
  input wire logic [7:0] matrix_col_oe,
  // Switch states, bit index is column times eight plus row
  input wire logic [63:0] press,
  // Row senses, pulled low where no closed switch drives them
  output logic [7:0] matrix_row_in
);
  always_comb begin
    matrix_row_in = 8'h00;
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 8; r++) begin
        if (matrix_col_out[c] && matrix_col_oe[c] && press[c*8+r]) begin
          matrix_row_in[r] = 1'b1;
        end
      end
    end
  end
endmodule // kms_key_matrix

//--- verification/key_matrix_scan_controller_bench.sv
// Self-checking bench for the key matrix scan controller
`timescale 1ns/1ps
`include "kms_map.svh"
module key_matrix_scan_controller_bench;
  localparam logic [6:0] BASE = 7'h38;
  localparam logic [7:0] RST [8] = '{8'h3f, 8'h0a, 8'hff, 8'h00,
                                     8'hfe, 8'h00, 8'h07, 8'h00};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] matrix_row_in;
  logic [7:0] matrix_col_out;
  logic [7:0] matrix_col_oe;
  logic key_irq_n_out;
  logic key_irq_n_oe;
  logic key_irq_n;
  logic [1:0] slave_addr_select = 2'h0;
  logic [6:0] slave_addr;
  logic [63:0] press = 64'h0;
  logic [7:0] v;
  logic [7:0] m;
  logic hi;
  int fails = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;
  // Open-drain pin with external pull-up
  assign key_irq_n = key_irq_n_oe ? key_irq_n_out : 1'b1;

  kms_ctrl #(.TICK_CYCLES(10), .SLAVE_BASE(BASE)) u_dut (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .matrix_row_in(matrix_row_in), .matrix_col_out(matrix_col_out),
    .matrix_col_oe(matrix_col_oe), .key_irq_n_out(key_irq_n_out),
    .key_irq_n_oe(key_irq_n_oe), .slave_addr_select(slave_addr_select),
    .slave_addr(slave_addr)
  );

  kms_key_matrix u_keys (
    .matrix_col_out(matrix_col_out), .matrix_col_oe(matrix_col_oe),
    .press(press), .matrix_row_in(matrix_row_in)
  );

  // ==========================================================
  // Tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic setk(input logic [63:0] k);
    @(posedge clk);
    press <= k;
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] d, input logic [3:0] be);
    logic w;
    int n;
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      w = avs_waitrequest;
      v = avs_readdata[7:0];
      hi = |avs_readdata[31:8];
    end while (w !== 1'b0 && n < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0) begin
      fails++;
      $display("[ERR] %0t bus timeout", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd(input logic [5:0] idx);
    bus(1'b0, idx, 8'h00, 4'h1);
    chk1(hi, 1'b0);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    rd(idx);
    chk8(v, exp);
  endtask

  // Polls the queue until an event shows up
  task automatic ev(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      cyc(50);
      rd(6'h00);
      n++;
    end while (v === `KMS_FIFO_EMPTY && n < 40);
    chk8(v, exp);
  endtask

  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, fails);
  endtask

  initial begin
    cyc(100000);
    fails++;
    $display("[ERR] %0t run timeout", $time);
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    cyc(3);
    reset <= 1'b0;
    cyc(2);
    chk8(matrix_col_oe, 8'hff);
    chk1(key_irq_n, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rd(6'(i));
      if (i == 1) chk1(v[7], 1'b1);
      chk8(i == 1 ? {1'b0, v[6:0]} : v, RST[i]);
    end
    wr(6'h00, 8'h00);
    rdc(6'h00, 8'h3f);
    bus(1'b1, 6'h03, 8'h1f, 4'h0);
    rdc(6'h03, 8'h00);
    done("reset");
    wr(6'h02, 8'h00);
    wr(6'h01, 8'h22);
    wr(6'h05, 8'hf1);
    setk(64'h1 << 29);
    ev(8'h1d);
    ev(8'h1d);
    wr(6'h05, 8'h00);
    setk(64'h0);
    ev(8'h9d);
    rdc(6'h00, 8'h3f);
    done("press");
    wr(6'h03, 8'h02);
    setk(64'h4);
    cyc(600);
    chk1(key_irq_n, 1'b1);
    setk(64'h4 | (64'h1 << 60));
    cyc(600);
    chk1(key_irq_n, 1'b0);
    rdc(6'h00, 8'h42);
    rdc(6'h00, 8'h3c);
    rdc(6'h00, 8'h3f);
    cyc(3);
    chk1(key_irq_n, 1'b1);
    setk(64'h1 << 60);
    cyc(600);
    setk(64'h0);
    cyc(600);
    rdc(6'h00, 8'hc2);
    rdc(6'h00, 8'hbc);
    wr(6'h03, 8'h00);
    wr(6'h04, 8'hfd);
    cyc(3);
    chk1(key_irq_n, 1'b0);
    wr(6'h04, 8'hfe);
    cyc(3);
    chk1(key_irq_n, 1'b1);
    wr(6'h03, 8'h20);
    setk(64'h1 << 8);
    cyc(600);
    chk1(key_irq_n, 1'b0);
    wr(6'h03, 8'h00);
    rdc(6'h00, 8'h08);
    cyc(3);
    chk1(key_irq_n, 1'b1);
    setk(64'h0);
    cyc(600);
    rdc(6'h00, 8'h88);
    done("interrupt");
    wr(6'h04, 8'h54);
    for (int n = 0; n < 8; n++) begin
      wr(6'h02, {3'(n), 5'h00});
      cyc(3);
      m = (n >= 1 && n <= 6) ? 8'(8'hff << (8 - n)) : 8'h00;
      chk8(matrix_col_oe, ~(m & 8'h54));
      chk8(matrix_col_out & m, 8'h00);
    end
    wr(6'h02, 8'hc0);
    setk(64'h1 << 45);
    cyc(600);
    rdc(6'h00, 8'h3f);
    setk(64'h0);
    wr(6'h02, 8'h00);
    wr(6'h04, 8'hfe);
    cyc(600);
    done("gpo");
    wr(6'h01, 8'h02);
    setk(64'hff);
    cyc(600);
    setk(64'hffff);
    cyc(600);
    setk(64'h1ffff);
    cyc(600);
    rdc(6'h00, `KMS_FIFO_OVF);
    for (int k = 0; k < 16; k++) begin
      rdc(6'h00, k == 15 ? 8'h0f : 8'h40 | 8'(k));
    end
    rdc(6'h00, 8'h3f);
    setk(64'h0);
    cyc(600);
    done("queue");
    setk(64'h1 << 9);
    cyc(600);
    wr(6'h06, 8'h01);
    wr(6'h01, 8'h0a);
    cyc(3000);
    rd(6'h01);
    chk1(v[7], 1'b0);
    setk(64'h0);
    cyc(3200);
    rd(6'h01);
    chk1(v[7], 1'b1);
    rdc(6'h00, 8'h09);
    setk(64'h1 << 9);
    cyc(100);
    rd(6'h01);
    chk1(v[7], 1'b0);
    ev(8'h09);
    setk(64'h0);
    cyc(600);
    wr(6'h01, 8'h80);
    setk(64'h1 << 9);
    cyc(600);
    rd(6'h01);
    chk1(v[7], 1'b1);
    rdc(6'h00, 8'h3f);
    setk(64'h0);
    done("sleep");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      slave_addr_select <= 2'(s);
      reset <= 1'b1;
      cyc(3);
      reset <= 1'b0;
      cyc(6);
      chk8({1'b0, slave_addr}, {1'b0, BASE[6:2], 2'(s)});
    end
    done("address");
    conclude();
  end
endmodule // key_matrix_scan_controller_bench
